// file: core/prio_regs.svh
// prio_regs.svh: register offsets, field positions, reset values,
// vector addresses and timing counts of the priority control block.
// assumes one inclusion per compilation unit; the guard absorbs repeats.
`ifndef PRIO_REGS_SVH
`define PRIO_REGS_SVH
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define CPEND_OFFSET 12'h008
`define CTRL_RESET 2'h3
`define CTRL_IRQ_EN 0
`define CTRL_CTR_EN 1
`define ST_PEND_LSB 0
`define ST_ACTIVE 8
`define ST_ALARM 9
`define ST_BUSY 10
`define ST_PRIO_LSB 12
`define ST_CELL_LSB 16
`define IRQ_COUNT 8
`define CELL_COUNT 29
`define VEC_TIMER_SIX 12'h804
`define VEC_TIMER_FIVE 12'h808
`define VEC_TIMER_THREE 12'h80c
`define VEC_TIMER_FOUR 12'h810
`define VEC_KEYPAD 12'h814
`define VEC_UPLINK 12'h81c
`define VEC_DOWNLINK 12'h820
`define VEC_HAND 12'h828
`define CTR_BASE 6'h14
`define CLK_MHZ 100
`define LONG_INC_MS 0.625
`define LONG_INC_CYCLES (`LONG_INC_MS * 1000.0 * `CLK_MHZ)
`define UPDATE_WAIT_CYCLES 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: core/prio_pkg.sv
// prio_pkg: state encodings and the packed state record of the block.
// assumes prio_regs.svh is found on the include path.
`include "prio_regs.svh"
package prio_pkg;
	// interrupt sequencer, one-hot
	typedef enum logic [1:0] {IRQ_IDLE = 2'b01, IRQ_SERVE = 2'b10} irq_state_t;
	// counter sequencer, one-hot
	typedef enum logic [1:0] {CTR_IDLE = 2'b01, CTR_BUSY = 2'b10} ctr_state_t;
	// per-cell counter flavour
	typedef enum logic [1:0] {
		KIND_PLAIN = 2'h0,
		KIND_ANGLE = 2'h1,
		KIND_SHIFT = 2'h2
	} cell_kind_t;
	// whole state of the top module
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] ctrl;
		irq_state_t irq_st;
		logic [`IRQ_COUNT-1:0] irq_pend;
		logic [2:0] irq_sel;
		logic [11:0] vector;
		logic order;
		ctr_state_t ctr_st;
		logic [`CELL_COUNT-1:0] up_pend;
		logic [`CELL_COUNT-1:0] dn_pend;
		logic [4:0] ctr_sel;
		logic ctr_dn;
		logic [11:0] ctr_addr;
		logic [5:0] instr;
		logic any_req;
		logic wait_on;
		logic [19:0] wait_cnt;
		logic [19:0] busy_cnt;
		logic alarm;
	} state_t;
endpackage

// file: core/prio_ctrl.sv
// prio_ctrl: program interrupt ranking and counter cell ranking with
// vector and counter address generation, counter alarm, axi4-lite regs.
// assumes all request pulses come from logic on ref_clk, one cycle wide.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "prio_regs.svh"

// Behaviour
// - twelve-bit vector per accepted interrupt
// - fixed interrupt priority, timer six first
// - timer overflows raise timer interrupts
// - any key press raises keypad interrupt
// - uplink flag bit raises uplink interrupt
// - downlink end pulse raises downlink interrupt
// - hand controller command raises its interrupt
// - fixed vector address per interrupt source
// - order code asserted with the vector
// - active interrupt blocks lower priority ones
// - returned vector clears the serviced request
// - counters live at words 0024..0060 octal
// - 29 cells, each raising address and request
// - request selects instruction kind; dual cells two
// - lowest address wins, blocks higher addresses
// - any-counter-request to sequencer and alarm; here sequencer only, the alarm uses the busy and wait counts
// - six-bit counter address, upper six zero
// - returned address plus reset pulse clears cell
// - alarm on missed update or long increment
module prio_ctrl #(
	parameter logic [`CELL_COUNT-1:0] DUAL_MASK = 29'h1ffffff0, // cells with two lines
	parameter logic [2*`CELL_COUNT-1:0] CELL_KIND = 58'h0, // 2 bits per cell
	parameter int UPDATE_WAIT_CYCLES = `UPDATE_WAIT_CYCLES, // increment_cycle_request to update limit
	parameter int LONG_INC_CYCLES = int'(`LONG_INC_CYCLES) // longest increment
) (
	input wire logic ref_clk, // 100 mhz clock
	input wire logic rst, // async reset, high
	input wire logic clk_en, // freezes all state when low
	input wire logic [11:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [11:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic timer_six_overflow, // time counter overflow pulse
	input wire logic timer_five_overflow, // time counter overflow pulse
	input wire logic timer_three_overflow, // time counter overflow pulse
	input wire logic timer_four_overflow, // time counter overflow pulse
	input wire logic key_pressed, // keyboard key pulse
	input wire logic uplink_flag_bit16, // uplink word complete pulse
	input wire logic downlink_end_pulse, // downlink word sent pulse
	input wire logic hand_controller_command, // hand controller pulse
	input wire logic [`CELL_COUNT-1:0] count_up_pulse, // plus-side incremental pulses
	input wire logic [`CELL_COUNT-1:0] count_down_pulse, // minus-side incremental pulses
	input wire logic [11:0] returned_address, // address back from processor
	input wire logic rupt_return_strobe, // returned address is a vector
	input wire logic counter_reset_pulse, // cell reset control pulse
	input wire logic increment_cycle_request, // sequencer increment request
	output logic [11:0] interrupt_address, // transfer routine address
	output logic interrupt_order_code, // force interrupt instruction
	output logic [11:0] counter_address, // counter word address
	output logic plus_increment, // counter instruction request
	output logic minus_increment, // counter instruction request
	output logic shift_increment, // counter instruction request
	output logic shift_add_increment, // counter instruction request
	output logic plus_angle_increment, // counter instruction request
	output logic minus_angle_increment, // counter instruction request
	output logic any_counter_request, // some cell pending
	output logic counter_alarm // sticky counter alarm
);
	import prio_pkg::*;

	////////////////////////////////////////////////////////////////////
	// helpers

	// lowest set bit index; lower index means higher rank
	// downward scan keeps the lowest hit
	function automatic logic [4:0] lowest_index(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// rank to transfer routine address
	function automatic logic [11:0] vector_of(input logic [2:0] idx);
		logic [11:0] a;
		unique case (idx)
			3'h0: a = `VEC_TIMER_SIX;
			3'h1: a = `VEC_TIMER_FIVE;
			3'h2: a = `VEC_TIMER_THREE;
			3'h3: a = `VEC_TIMER_FOUR;
			3'h4: a = `VEC_KEYPAD;
			3'h5: a = `VEC_UPLINK;
			3'h6: a = `VEC_DOWNLINK;
			3'h7: a = `VEC_HAND;
		endcase
		return a;
	endfunction

	// cell flavour and side to one-hot instruction request
	function automatic logic [5:0] cell_instr(input logic [1:0] kind, input logic dn);
		logic [5:0] r;
		unique case (kind)
			KIND_ANGLE: r = dn ? 6'h20 : 6'h10;
			KIND_SHIFT: r = dn ? 6'h08 : 6'h04;
			default: r = dn ? 6'h02 : 6'h01; // plain and the unused code
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// state record

	localparam state_t RESET_STATE = '{
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		ctrl: `CTRL_RESET, irq_st: IRQ_IDLE, ctr_st: CTR_IDLE,
		default: '0
	};

	state_t q; // registered state
	state_t n; // next state

	////////////////////////////////////////////////////////////////////
	// next-state logic

	// one process for bus, interrupt ranking, cells and alarm
	always_comb begin
		logic [`IRQ_COUNT-1:0] irq_set;
		logic [`IRQ_COUNT-1:0] irq_clr;
		logic [`CELL_COUNT-1:0] up_clr;
		logic [`CELL_COUNT-1:0] dn_clr;
		logic [`CELL_COUNT-1:0] cells;
		logic [4:0] pick;
		logic [1:0] kind;
		logic upd;
		logic alarm_set;
		logic alarm_clr;
		logic wr_ok;
		irq_set = '0;
		irq_clr = '0;
		up_clr = '0;
		dn_clr = '0;
		cells = q.up_pend | q.dn_pend;
		pick = 5'h00;
		kind = 2'h0;
		upd = 1'b0;
		alarm_set = 1'b0;
		alarm_clr = 1'b0;
		wr_ok = 1'b0;
		n = q;

		// write address and data taken in either order
		if (s_axi_awvalid && q.awready) begin
			n.awready = 1'b0;
			n.aw_held = 1'b1;
			n.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			n.wready = 1'b0;
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		// pending response stalls new writes
		// both halves held: perform the write, answer
		if (q.aw_held && q.w_held && !q.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			wr_ok = 1'b1;
			unique case (q.waddr)
				`CTRL_OFFSET: begin
					if (q.wstrb[0]) begin
						n.ctrl = q.wdata[1:0];
					end
				end
				`STATUS_OFFSET: begin
					// write one to the alarm bit clears it
					alarm_clr = q.wstrb[1] & q.wdata[`ST_ALARM];
				end
				`CPEND_OFFSET: begin
					// read-only, write ignored
				end
				default: wr_ok = 1'b0;
			endcase
			n.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		// response taken: reopen both write channels
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// read: one outstanding, data captured at address
		// snapshot stands until rready
		if (s_axi_arvalid && q.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = 32'h0;
			n.rresp = `RESP_OKAY;
			unique case (s_axi_araddr)
				`CTRL_OFFSET: n.rdata[1:0] = q.ctrl;
				`STATUS_OFFSET: begin
					n.rdata[`ST_PEND_LSB +: `IRQ_COUNT] = q.irq_pend;
					n.rdata[`ST_ACTIVE] = q.order;
					n.rdata[`ST_ALARM] = q.alarm;
					n.rdata[`ST_BUSY] = (q.ctr_st == CTR_BUSY);
					n.rdata[`ST_PRIO_LSB +: 3] = q.irq_sel;
					n.rdata[`ST_CELL_LSB +: 5] = q.ctr_sel;
				end
				`CPEND_OFFSET: n.rdata[`CELL_COUNT-1:0] = cells;
				default: n.rresp = `RESP_SLVERR;
			endcase
		end
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// interrupt sources, bit 0 ranks first
		// same-clock pulses, no synchroniser
		irq_set[0] = timer_six_overflow;
		irq_set[1] = timer_five_overflow;
		irq_set[2] = timer_three_overflow;
		irq_set[3] = timer_four_overflow;
		irq_set[4] = key_pressed;
		irq_set[5] = uplink_flag_bit16;
		irq_set[6] = downlink_end_pulse;
		irq_set[7] = hand_controller_command;

		// returned vector clears only the request being serviced
		if (q.irq_st == IRQ_SERVE && rupt_return_strobe && returned_address == q.vector) begin
			irq_clr[q.irq_sel] = 1'b1;
		end
		// a new event in the clearing cycle survives
		n.irq_pend = (q.irq_pend & ~irq_clr) | irq_set;

		// interrupt sequencer
		unique case (q.irq_st)
			IRQ_IDLE: begin
				if (q.ctrl[`CTRL_IRQ_EN] && (|q.irq_pend)) begin
					pick = lowest_index({24'h0, q.irq_pend});
					n.irq_sel = pick[2:0];
					n.vector = vector_of(pick[2:0]);
					n.order = 1'b1;
					n.irq_st = IRQ_SERVE;
				end
			end
			IRQ_SERVE: begin
				// selection frozen until return; lower ones wait
				// later higher ones wait too
				if (irq_clr[q.irq_sel]) begin
					n.order = 1'b0;
					n.irq_st = IRQ_IDLE;
				end
			end
		endcase

		// counter update seen: matching address with reset pulse
		upd = (q.ctr_st == CTR_BUSY) && counter_reset_pulse
			&& returned_address == q.ctr_addr;
		if (upd) begin
			if (q.ctr_dn) begin
				dn_clr[q.ctr_sel] = 1'b1;
			end else begin
				up_clr[q.ctr_sel] = 1'b1;
			end
		end
		// single-line cells ignore the minus-side input
		// minus side follows the plus side
		n.up_pend = (q.up_pend & ~up_clr) | count_up_pulse;
		n.dn_pend = (q.dn_pend & ~dn_clr) | (count_down_pulse & DUAL_MASK);
		n.any_req = |(n.up_pend | n.dn_pend);

		// counter sequencer
		unique case (q.ctr_st)
			CTR_IDLE: begin
				if (q.ctrl[`CTRL_CTR_EN] && (|cells)) begin
					pick = lowest_index({3'h0, cells});
					kind = CELL_KIND[{pick, 1'b0} +: 2];
					n.ctr_sel = pick;
					n.ctr_dn = !q.up_pend[pick]; // plus side first
					n.ctr_addr = {6'h00, `CTR_BASE + {1'b0, pick}};
					n.instr = cell_instr(kind, !q.up_pend[pick]);
					n.busy_cnt = 20'h0;
					n.ctr_st = CTR_BUSY;
				end
			end
			CTR_BUSY: begin
				// higher addresses wait until this cell clears
				// stuck cell keeps the alarm up
				if (upd) begin
					n.instr = 6'h00;
					n.ctr_st = CTR_IDLE;
				end else if (q.busy_cnt == 20'(LONG_INC_CYCLES - 1)) begin
					alarm_set = 1'b1;
				end else begin
					n.busy_cnt = q.busy_cnt + 20'h1;
				end
			end
		endcase

		// missed update watch after each increment request
		// new request restarts the watch
		if (q.wait_on) begin
			if (upd) begin
				n.wait_on = 1'b0;
			end else if (q.wait_cnt == 20'(UPDATE_WAIT_CYCLES - 1)) begin
				alarm_set = 1'b1;
				n.wait_on = 1'b0;
			end else begin
				n.wait_cnt = q.wait_cnt + 20'h1;
			end
		end
		if (increment_cycle_request) begin
			n.wait_on = 1'b1;
			n.wait_cnt = 20'h0;
		end
		// sticky alarm, a new alarm beats the clear
		n.alarm = (q.alarm & ~alarm_clr) | alarm_set;
	end

	////////////////////////////////////////////////////////////////////
	// state register

	// clock enable holds everything, bus included
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= RESET_STATE;
		end else if (clk_en) begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, straight from the state register

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign interrupt_address = q.vector;
	assign interrupt_order_code = q.order;
	assign counter_address = q.ctr_addr;
	assign plus_increment = q.instr[0];
	assign minus_increment = q.instr[1];
	assign shift_increment = q.instr[2];
	assign shift_add_increment = q.instr[3];
	assign plus_angle_increment = q.instr[4];
	assign minus_angle_increment = q.instr[5];
	assign any_counter_request = q.any_req;
	assign counter_alarm = q.alarm;
endmodule

// file: test/prio_ctrl_properties.sv
// port-level properties of the priority control block
// assumes clk_en drops only while the block is idle
`timescale 1ns/10ps
module prio_ctrl_chk (
	input wire logic ref_clk, // clock
	input wire logic rst, // async reset
	input wire logic [11:0] returned_address, // address back
	input wire logic rupt_return_strobe, // vector returned
	input wire logic counter_reset_pulse, // counter address returned
	input wire logic increment_cycle_request, // increment request
	input wire logic [11:0] interrupt_address, // vector out
	input wire logic interrupt_order_code, // order code
	input wire logic [11:0] counter_address, // counter word
	input wire logic plus_increment, // request
	input wire logic minus_increment, // request
	input wire logic shift_increment, // request
	input wire logic shift_add_increment, // request
	input wire logic plus_angle_increment, // request
	input wire logic minus_angle_increment, // request
	input wire logic any_counter_request, // cell pending
	input wire logic counter_alarm // alarm
);
	logic [5:0] ins; // all counter requests
	logic [4:0] wait_q; // cycles since increment request
	logic [4:0] wait_d; // next wait count
	assign ins = {minus_angle_increment, plus_angle_increment, shift_add_increment,
		shift_increment, minus_increment, plus_increment};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// watch of an unanswered increment request; saturates at 31
	always_comb begin
		wait_d = wait_q;
		if (increment_cycle_request) begin
			wait_d = 5'h1;
		end else if (counter_reset_pulse) begin
			wait_d = 5'h0;
		end else if (wait_q != 5'h0 && wait_q != 5'h1f) begin
			wait_d = wait_q + 5'h1;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 5'h0;
		end else begin
			wait_q <= wait_d;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence vec_back;
		rupt_return_strobe && returned_address == interrupt_address;
	endsequence
	sequence ctr_back;
		counter_reset_pulse && returned_address == counter_address;
	endsequence
	AST_VEC_SET: assert property (interrupt_order_code |-> interrupt_address inside
		{12'h804, 12'h808, 12'h80c, 12'h810, 12'h814, 12'h81c, 12'h820, 12'h828})
		else $error("order code with a foreign vector");
	AST_ORDER_HOLD: assert property (interrupt_order_code && !(rupt_return_strobe &&
		returned_address == interrupt_address) |=> interrupt_order_code && $stable(interrupt_address))
		else $error("order code or vector moved before return");
	AST_ORDER_DROP: assert property (interrupt_order_code ##0 vec_back |=> !interrupt_order_code)
		else $error("order code kept after vector return");
	AST_ONE_INSTR: assert property ($onehot0(ins))
		else $error("several counter requests at once");
	AST_CTR_ADDR: assert property (ins != 6'h0 |-> counter_address[11:6] == 6'h0 &&
		counter_address[5:0] inside {[6'h14:6'h30]})
		else $error("counter address outside the counter words");
	AST_CTR_HOLD: assert property (ins != 6'h0 && !(counter_reset_pulse &&
		returned_address == counter_address) |=> $stable(ins) && $stable(counter_address))
		else $error("counter request moved before clear");
	AST_CTR_CLEAR: assert property (ins != 6'h0 ##0 ctr_back |=> ins == 6'h0)
		else $error("counter request kept after clear");
	AST_ANY_REQ: assert property (ins != 6'h0 |-> any_counter_request)
		else $error("counter served without any-request");
	AST_MISSED_UPDATE: assert property (wait_q == 5'h10 |-> ##[0:3] counter_alarm)
		else $error("no alarm on unanswered increment request");
endmodule
bind prio_ctrl prio_ctrl_chk chk (.ref_clk, .rst, .returned_address, .rupt_return_strobe,
	.counter_reset_pulse, .increment_cycle_request, .interrupt_address, .interrupt_order_code,
	.counter_address, .plus_increment, .minus_increment, .shift_increment, .shift_add_increment,
	.plus_angle_increment, .minus_angle_increment, .any_counter_request, .counter_alarm);

// file: test/seq_model.sv
// sequencer and processor stand-in answering orders and counter requests
// assumes one shared return path for vectors and counter addresses
`timescale 1ns/10ps
module seq_model (
	input wire logic ref_clk, // clock
	input wire logic rst, // async reset
	input wire logic slow, // long answer delay
	input wire logic stall, // withhold counter clears
	input wire logic order, // interrupt order code
	input wire logic [11:0] vec, // interrupt address
	input wire logic [5:0] inc, // counter requests
	input wire logic [11:0] caddr, // counter address
	output logic rupt_return_strobe, // vector returned
	output logic counter_reset_pulse, // counter address returned
	output logic increment_cycle_request, // increment request
	output logic [11:0] returned_address // address lines
);
	logic busy; // a service under way
	logic is_ctr; // service is a counter
	logic [3:0] cnt; // answer delay, then guard
	// counters first; guard lets the outputs drop before the next look
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			is_ctr <= 1'b0;
			cnt <= 4'h0;
			rupt_return_strobe <= 1'b0;
			counter_reset_pulse <= 1'b0;
			increment_cycle_request <= 1'b0;
			returned_address <= 12'h0;
		end else begin
			rupt_return_strobe <= 1'b0;
			counter_reset_pulse <= 1'b0;
			increment_cycle_request <= 1'b0;
			returned_address <= ~returned_address; // lines not held when idle
			if (cnt != 4'h0) cnt <= cnt - 4'h1;
			if (!busy && cnt == 4'h0 && (inc != 6'h0 || order)) begin
				busy <= 1'b1;
				is_ctr <= inc != 6'h0;
				increment_cycle_request <= inc != 6'h0;
				cnt <= slow ? 4'h9 : 4'h1;
			end else if (busy && cnt == 4'h0 && !(is_ctr && stall)) begin
				busy <= 1'b0;
				cnt <= 4'h3;
				returned_address <= is_ctr ? caddr : vec;
				counter_reset_pulse <= is_ctr;
				rupt_return_strobe <= !is_ctr;
			end
		end
	end
endmodule

// file: test/tb_interrupt_and_counter_priority.sv
// self-checking bench of prio_ctrl with the sequencer stand-in
// assumes prio_regs.svh on the include path
`timescale 1ns/10ps
`include "prio_regs.svh"
module tb_interrupt_and_counter_priority;
	localparam logic [28:0] DUAL = 29'h1ffffff0; // two-line cells
	localparam logic [57:0] KIND = 58'h2400; // cell 5 angle, cell 6 shift
	logic ref_clk = 0, rst = 1, clk_en = 1, stall = 0, slow = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, timer_six_overflow = 0, timer_five_overflow = 0;
	logic timer_three_overflow = 0, timer_four_overflow = 0, key_pressed = 0;
	logic uplink_flag_bit16 = 0, downlink_end_pulse = 0, hand_controller_command = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [28:0] count_up_pulse = 0, count_down_pulse = 0, um, dm;
	wire [11:0] returned_address, interrupt_address, counter_address;
	wire rupt_return_strobe, counter_reset_pulse, increment_cycle_request;
	wire interrupt_order_code, plus_increment, minus_increment, shift_increment;
	wire shift_add_increment, plus_angle_increment, minus_angle_increment;
	wire any_counter_request, counter_alarm;
	wire [5:0] inc = {minus_angle_increment, plus_angle_increment, shift_add_increment,
		shift_increment, minus_increment, plus_increment};
	logic [11:0] vec_tab [8] = '{12'h804, 12'h808, 12'h80c, 12'h810, 12'h814, 12'h81c,
		12'h820, 12'h828}; // vectors in rank order
	logic [11:0] got_vec [$];
	logic [17:0] got_ctr [$], exp_ctr [$];
	logic prev_order = 0;
	logic [5:0] prev_inc = 0;
	int n_fail = 0, check_count = 0, i, t;
	prio_ctrl #(.DUAL_MASK(DUAL), .CELL_KIND(KIND), .LONG_INC_CYCLES(40)) dut (.ref_clk, .rst,
		.clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.timer_six_overflow, .timer_five_overflow, .timer_three_overflow, .timer_four_overflow,
		.key_pressed, .uplink_flag_bit16, .downlink_end_pulse, .hand_controller_command,
		.count_up_pulse, .count_down_pulse, .returned_address, .rupt_return_strobe,
		.counter_reset_pulse, .increment_cycle_request, .interrupt_address,
		.interrupt_order_code, .counter_address, .plus_increment, .minus_increment,
		.shift_increment, .shift_add_increment, .plus_angle_increment, .minus_angle_increment,
		.any_counter_request, .counter_alarm);
	seq_model far (.ref_clk, .rst, .slow, .stall, .order(interrupt_order_code),
		.vec(interrupt_address), .inc, .caddr(counter_address), .rupt_return_strobe,
		.counter_reset_pulse, .increment_cycle_request, .returned_address);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	// log each new order and each new counter request
	always @(posedge ref_clk) begin
		prev_order <= interrupt_order_code;
		prev_inc <= inc;
		if (interrupt_order_code && !prev_order) got_vec.push_back(interrupt_address);
		if (inc != 6'h0 && prev_inc == 6'h0) got_ctr.push_back({inc, counter_address});
	end
	// request line and address expected for one cell side
	function automatic logic [17:0] ctr_exp(input int c, input logic dn);
		logic [1:0] k;
		int b;
		k = KIND[2*c +: 2];
		b = (k == 2'h1) ? 4 : (k == 2'h2) ? 2 : 0;
		return {6'h1 << (b + dn), 6'h0, 6'(c + 20)};
	endfunction
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic final_report;
		if (n_fail == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// bounded waits; an exhausted bound ends the run
	task automatic wait_idle;
		int k, q;
		q = 0;
		for (k = 0; k < 3000 && q < 20; k++) begin
			@(posedge ref_clk);
			q = (interrupt_order_code || any_counter_request || inc != 6'h0) ? 0 : q + 1;
		end
		if (q < 20) begin
			n_fail++;
			final_report();
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (k = 0; k < 50 && (k == 0 || s_axi_awvalid || s_axi_wvalid || s_axi_bready); k++) begin
			@(posedge ref_clk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 0;
		end
		if (k >= 50) begin
			n_fail++;
			final_report();
		end
	endtask
	task automatic axi_rd(input logic [11:0] a);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (k = 0; k < 50 && (k == 0 || s_axi_rready); k++) begin
			@(posedge ref_clk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
		if (k >= 50) begin
			n_fail++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(24));
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		axi_rd(12'h000);
		chk("ctrl reset", 32'h3, d);
		axi_rd(12'h00c);
		chk("unmapped resp", 32'h2, 32'(r));
		// key pulse during a frozen cycle is lost
		{clk_en, key_pressed} <= 2'b01;
		@(posedge ref_clk);
		{clk_en, key_pressed} <= 2'b10;
		repeat (4) @(posedge ref_clk);
		chk("frozen key", 32'h0, 32'(interrupt_order_code));
		// all eight sources at once while interrupts are off
		axi_wr(12'h000, 32'h2, 4'h1);
		{hand_controller_command, downlink_end_pulse, uplink_flag_bit16, key_pressed,
			timer_four_overflow, timer_three_overflow, timer_five_overflow,
			timer_six_overflow} <= 8'hff;
		@(posedge ref_clk);
		{hand_controller_command, downlink_end_pulse, uplink_flag_bit16, key_pressed,
			timer_four_overflow, timer_three_overflow, timer_five_overflow,
			timer_six_overflow} <= 8'h0;
		repeat (10) @(posedge ref_clk);
		chk("order while off", 32'h0, 32'(interrupt_order_code));
		slow <= 1;
		axi_wr(12'h000, 32'h3, 4'h1);
		wait_idle();
		for (i = 0; i < 8; i++) chk("vector", 32'(vec_tab[i]), 32'(got_vec[i]));
		// full set first, then random sets of cell pulses
		for (t = 0; t < 3; t++) begin
			um = (t == 0) ? '1 : 29'($urandom);
			dm = (t == 0) ? '1 : 29'($urandom);
			slow <= t[0];
			exp_ctr.delete();
			got_ctr.delete();
			for (i = 0; i < 29; i++) begin
				if (um[i]) exp_ctr.push_back(ctr_exp(i, 1'b0));
				if (dm[i] && DUAL[i]) exp_ctr.push_back(ctr_exp(i, 1'b1));
			end
			count_up_pulse <= um;
			count_down_pulse <= dm;
			@(posedge ref_clk);
			count_up_pulse <= '0;
			count_down_pulse <= '0;
			wait_idle();
			chk("service count", exp_ctr.size(), got_ctr.size());
			foreach (exp_ctr[i]) chk("service", 32'(exp_ctr[i]), 32'(got_ctr[i]));
		end
		chk("alarm quiet", 32'h0, 32'(counter_alarm));
		// clear withheld: missed update raises the alarm
		stall <= 1;
		count_up_pulse <= 29'h1;
		@(posedge ref_clk);
		count_up_pulse <= '0;
		repeat (28) @(posedge ref_clk);
		chk("missed update alarm", 32'h1, 32'(counter_alarm));
		axi_wr(12'h004, 32'h200, 4'h2);
		chk("alarm cleared", 32'h0, 32'(counter_alarm));
		repeat (15) @(posedge ref_clk);
		chk("long increment alarm", 32'h1, 32'(counter_alarm));
		stall <= 0;
		wait_idle();
		axi_rd(12'h004);
		chk("status alarm", 32'h1, 32'(d[9]));
		axi_wr(12'h004, 32'h200, 4'h2);
		axi_rd(12'h004);
		chk("status alarm cleared", 32'h0, 32'(d[9]));
		chk("alarm port", 32'h0, 32'(counter_alarm));
		final_report();
	end
endmodule
